// *** design/cmt_consts.vh ***
/*
  Constants for the channel match and transition action block: register
  offsets, control field positions, channel mode codes and edge selections.
  Assumes it is included by bare name from the design file.
*/
`ifndef CMT_CONSTS_VH
`define CMT_CONSTS_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define CMT_ADDR_W        4
`define CMT_TB_W          24
`define CMT_CTRL_W        12

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CMT_ADDR_CTRL     4'h0
`define CMT_ADDR_MATCH_A  4'h1
`define CMT_ADDR_MATCH_B  4'h2
`define CMT_ADDR_STATUS   4'h3
`define CMT_ADDR_CAPT_A   4'h4
`define CMT_ADDR_CAPT_B   4'h5

// ----------------------------------------------------------------------------
// Control field positions and reset value
// ----------------------------------------------------------------------------
`define CMT_MODE_MSB      2
`define CMT_MODE_LSB      0
`define CMT_ESA_MSB       5
`define CMT_ESA_LSB       4
`define CMT_ESB_MSB       7
`define CMT_ESB_LSB       6
`define CMT_TBSA_BIT      8
`define CMT_TBSB_BIT      9
`define CMT_GEA_BIT       10
`define CMT_GEB_BIT       11
`define CMT_CTRL_RST      12'h000

// ----------------------------------------------------------------------------
// Channel modes
// ----------------------------------------------------------------------------
`define CMT_MODE_EM_FREE_DT   3'h0
`define CMT_MODE_EM_LOCK_ST   3'h1
`define CMT_MODE_EM_LOCK_DT   3'h2
`define CMT_MODE_SECOND_MATCH_SINGLE_EDGE_MODE        3'h3
`define CMT_MODE_SECOND_MATCH_DOUBLE_EDGE_MODE        3'h4
`define CMT_MODE_ORD_ST       3'h5
`define CMT_MODE_ORD_DT       3'h6

// ----------------------------------------------------------------------------
// Edge selections
// ----------------------------------------------------------------------------
`define CMT_EDGE_OFF      2'h0
`define CMT_EDGE_RISE     2'h1
`define CMT_EDGE_FALL     2'h2
`define CMT_EDGE_ANY      2'h3

`endif

// *** design/cmt_channel_action.v ***
/*
  Channel action logic of one timer channel: two action units, each with a
  match comparator and capture register, match and transition latches,
  blocking, ordering and service requests of seven channel modes.
  Assumes timebase counters on clk, an asynchronous input pin, and an engine
  that pulses thread_switch_point and flag_clear on clk.
*/
// Our own choices: the strobed register port and the address map.
`include "cmt_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module cmt_channel_action (
  input  wire                  clk,
  input  wire                  nrst,
  input  wire                  ce,
  input  wire [3:0]            addr,
  input  wire [31:0]           wdata,
  input  wire                  wr,
  input  wire                  rd,
  output reg  [31:0]           rdata,
  input  wire                  pin_in,
  output reg                   pin_out,
  input  wire [23:0]           timebase_counter_1,
  input  wire [23:0]           timebase_counter_2,
  input  wire                  thread_switch_point,
  input  wire [3:0]            flag_clear,
  output wire                  vector_first_match_second_edge,
  output wire                  vector_second_match_first_edge,
  output wire                  service_request,
  output reg  [3:0]            sampled_flags,
  output reg  [23:0]           engine_capture_copy_a,
  output reg  [23:0]           engine_capture_copy_b
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  reg  [11:0] ctrl_reg;
  reg  [23:0] match_val_a_reg;
  reg  [23:0] match_val_b_reg;
  reg         armed_a_reg;
  reg         armed_b_reg;
  reg         match_a_hit_latch;
  reg         match_b_hit_latch;
  reg         edge_a_seen_latch;
  reg         edge_b_seen_latch;
  reg  [3:0]  req_reg;
  reg  [23:0] capture_a_reg;
  reg  [23:0] capture_b_reg;
  reg         cap_edge_a_reg;
  reg         cap_edge_b_reg;
  reg         pin_s1_reg;
  reg         pin_s2_reg;
  reg         pin_prev_reg;

  // --------------------------------------------------------------------------
  // Control decode
  // --------------------------------------------------------------------------
  wire [2:0]  mode    = ctrl_reg[`CMT_MODE_MSB:`CMT_MODE_LSB];
  wire [23:0] tb_a    = ctrl_reg[`CMT_TBSA_BIT] ? timebase_counter_2 : timebase_counter_1;
  wire [23:0] tb_b    = ctrl_reg[`CMT_TBSB_BIT] ? timebase_counter_2 : timebase_counter_1;
  wire [47:0] tb_all  = {tb_b, tb_a};
  wire [47:0] val_all = {match_val_b_reg, match_val_a_reg};
  wire [3:0]  esel    = {ctrl_reg[`CMT_ESB_MSB:`CMT_ESB_LSB],
                         ctrl_reg[`CMT_ESA_MSB:`CMT_ESA_LSB]};
  wire [1:0]  ge      = {ctrl_reg[`CMT_GEB_BIT], ctrl_reg[`CMT_GEA_BIT]};
  wire        rise    = pin_s2_reg & ~pin_prev_reg;
  wire        fall    = ~pin_s2_reg & pin_prev_reg;
  wire        single_edge = (mode == `CMT_MODE_EM_LOCK_ST) | (mode == `CMT_MODE_SECOND_MATCH_SINGLE_EDGE_MODE) |
                            (mode == `CMT_MODE_ORD_ST);

  // --------------------------------------------------------------------------
  // Comparators and edge detectors per action unit
  // --------------------------------------------------------------------------
  wire [1:0]  cmp_hit;
  wire [1:0]  edge_raw;
  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1) begin : g_unit
      wire [23:0] tbu  = tb_all[u*24 +: 24];
      wire [23:0] valu = val_all[u*24 +: 24];
      wire [1:0]  su   = esel[u*2 +: 2];
      assign cmp_hit[u]  = ge[u] ? (tbu >= valu) : (tbu == valu);
      assign edge_raw[u] = ((su == `CMT_EDGE_RISE) & rise) |
                           ((su == `CMT_EDGE_FALL) & fall) |
                           ((su == `CMT_EDGE_ANY) & (rise | fall));
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Mode enables and request masks
  // --------------------------------------------------------------------------
  reg        ma_en;
  reg        mb_en;
  reg        ea_en;
  reg        eb_en;
  reg  [3:0] rq_mask;

  always @* begin
    ma_en   = armed_a_reg & ~match_a_hit_latch;
    mb_en   = armed_b_reg & ~match_b_hit_latch;
    ea_en   = ~edge_a_seen_latch;
    eb_en   = edge_a_seen_latch & ~edge_b_seen_latch;
    rq_mask = 4'h0;
    case (mode)
      `CMT_MODE_EM_FREE_DT: begin
        ma_en   = ma_en & ~edge_a_seen_latch;
        mb_en   = mb_en & ~edge_b_seen_latch;
        rq_mask = 4'hb;
      end
      `CMT_MODE_EM_LOCK_ST: begin
        ma_en   = ma_en & ~match_b_hit_latch & ~edge_a_seen_latch;
        mb_en   = mb_en & ~match_a_hit_latch & ~edge_a_seen_latch;
        rq_mask = 4'h7;
      end
      `CMT_MODE_EM_LOCK_DT: begin
        ma_en   = ma_en & ~match_b_hit_latch & ~edge_a_seen_latch;
        mb_en   = mb_en & ~match_a_hit_latch & ~edge_b_seen_latch;
        rq_mask = 4'hb;
      end
      `CMT_MODE_SECOND_MATCH_SINGLE_EDGE_MODE: begin
        ma_en   = ma_en & ~match_b_hit_latch;
        mb_en   = mb_en & ~edge_a_seen_latch;
        ea_en   = ea_en & match_a_hit_latch;
        rq_mask = 4'h6;
      end
      `CMT_MODE_SECOND_MATCH_DOUBLE_EDGE_MODE: begin
        ma_en   = ma_en & ~match_b_hit_latch;
        mb_en   = mb_en & ~edge_b_seen_latch;
        ea_en   = ea_en & match_a_hit_latch;
        rq_mask = 4'ha;
      end
      `CMT_MODE_ORD_ST: begin
        mb_en   = mb_en & match_a_hit_latch & ~edge_a_seen_latch;
        ea_en   = ea_en & match_a_hit_latch & ~match_b_hit_latch;
        rq_mask = 4'h6;
      end
      `CMT_MODE_ORD_DT: begin
        mb_en   = mb_en & match_a_hit_latch & ~edge_b_seen_latch;
        ea_en   = ea_en & match_a_hit_latch & ~match_b_hit_latch;
        eb_en   = eb_en & ~match_b_hit_latch;
        rq_mask = 4'ha;
      end
      default: begin
        ma_en = 1'b0;
        mb_en = 1'b0;
        ea_en = 1'b0;
        eb_en = 1'b0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Events and captures
  // --------------------------------------------------------------------------
  wire [3:0] set_ev = {eb_en & edge_raw[1], ea_en & edge_raw[0],
                       mb_en & cmp_hit[1], ma_en & cmp_hit[0]};
  wire       sw_clr = wr & (addr == `CMT_ADDR_STATUS);
  wire [3:0] clr_ev = flag_clear | (sw_clr ? wdata[3:0] : 4'h0);
  wire       both_on_match = (mode == `CMT_MODE_EM_LOCK_ST) |
                             ((mode == `CMT_MODE_EM_LOCK_DT) & ~edge_a_seen_latch);
  wire       any_match = set_ev[0] | set_ev[1];
  wire       ld_edge_a = set_ev[2];
  wire       ld_edge_b = set_ev[3] | (set_ev[2] & single_edge);
  wire       ld_mat_a  = (set_ev[0] | (both_on_match & any_match)) & ~cap_edge_a_reg;
  wire       ld_mat_b  = (set_ev[1] | (both_on_match & any_match)) & ~cap_edge_b_reg;
  wire [3:0] latch_now = {edge_b_seen_latch, edge_a_seen_latch,
                          match_b_hit_latch, match_a_hit_latch};
  wire [3:0] latch_next;
  wire [3:0] req_next;

  // --------------------------------------------------------------------------
  // Flag and request slices, set wins over clear
  // --------------------------------------------------------------------------
  genvar f;
  generate
    for (f = 0; f < 4; f = f + 1) begin : g_flag
      assign latch_next[f] = set_ev[f] | (latch_now[f] & ~clr_ev[f]);
      assign req_next[f]   = (set_ev[f] & rq_mask[f]) | (req_reg[f] & ~clr_ev[f]);
    end
  endgenerate

  assign vector_first_match_second_edge = req_reg[0] | req_reg[3];
  assign vector_second_match_first_edge = req_reg[1] | req_reg[2];
  assign service_request = |req_reg;

  // --------------------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1_reg   <= 1'b0;
      pin_s2_reg   <= 1'b0;
      pin_prev_reg <= 1'b0;
    end else if (ce) begin
      pin_s1_reg   <= pin_in;
      pin_s2_reg   <= pin_s1_reg;
      pin_prev_reg <= pin_s2_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Latches, captures and output pin
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      match_a_hit_latch <= 1'b0;
      match_b_hit_latch <= 1'b0;
      edge_a_seen_latch <= 1'b0;
      edge_b_seen_latch <= 1'b0;
      req_reg           <= 4'h0;
      capture_a_reg     <= 24'h000000;
      capture_b_reg     <= 24'h000000;
      cap_edge_a_reg    <= 1'b0;
      cap_edge_b_reg    <= 1'b0;
      pin_out           <= 1'b0;
    end else if (ce) begin
      match_a_hit_latch <= latch_next[0];
      match_b_hit_latch <= latch_next[1];
      edge_a_seen_latch <= latch_next[2];
      edge_b_seen_latch <= latch_next[3];
      req_reg           <= req_next;
      if (ld_edge_a)
        capture_a_reg <= tb_a;
      else if (ld_mat_a)
        capture_a_reg <= tb_a;
      if (ld_edge_b)
        capture_b_reg <= tb_b;
      else if (ld_mat_b)
        capture_b_reg <= tb_b;
      cap_edge_a_reg <= ld_edge_a | (cap_edge_a_reg & latch_next[2]);
      cap_edge_b_reg <= ld_edge_b | (cap_edge_b_reg & (latch_next[2] | latch_next[3]));
      if (set_ev[1])
        pin_out <= 1'b0;
      else if (set_ev[0])
        pin_out <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Engine copy at thread switch
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sampled_flags         <= 4'h0;
      engine_capture_copy_a <= 24'h000000;
      engine_capture_copy_b <= 24'h000000;
    end else if (ce && thread_switch_point) begin
      sampled_flags         <= latch_now;
      engine_capture_copy_a <= capture_a_reg;
      engine_capture_copy_b <= capture_b_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg        <= `CMT_CTRL_RST;
      match_val_a_reg <= 24'h000000;
      match_val_b_reg <= 24'h000000;
      armed_a_reg     <= 1'b0;
      armed_b_reg     <= 1'b0;
      rdata           <= 32'h00000000;
    end else if (ce) begin
      if (wr && addr == `CMT_ADDR_CTRL)
        ctrl_reg <= wdata[11:0];
      if (wr && addr == `CMT_ADDR_MATCH_A) begin
        match_val_a_reg <= wdata[23:0];
        armed_a_reg     <= 1'b1;
      end
      if (wr && addr == `CMT_ADDR_MATCH_B) begin
        match_val_b_reg <= wdata[23:0];
        armed_b_reg     <= 1'b1;
      end
      if (rd) begin
        case (addr)
          `CMT_ADDR_CTRL:    rdata <= {20'h00000, ctrl_reg};
          `CMT_ADDR_MATCH_A: rdata <= {8'h00, match_val_a_reg};
          `CMT_ADDR_MATCH_B: rdata <= {8'h00, match_val_b_reg};
          `CMT_ADDR_STATUS:  rdata <= {24'h000000, req_reg, latch_now};
          `CMT_ADDR_CAPT_A:  rdata <= {8'h00, capture_a_reg};
          `CMT_ADDR_CAPT_B:  rdata <= {8'h00, capture_b_reg};
          default:           rdata <= 32'h00000000;
        endcase
      end else begin
        rdata <= 32'h00000000;
      end
    end
  end

endmodule // cmt_channel_action

`default_nettype wire

// *** test/cmt_engine_model.sv ***
/*
  Engine scheduler model: serves a pending request after a lag, pulses the
  thread switch, then clears the flags that it sampled.
  Assumes it shares clk and nrst with the channel action block.
*/
`timescale 1ns/1ps
`default_nettype none

module cmt_engine_model (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       service_request,
  input  wire logic [3:0] sampled_flags,
  input  wire logic [7:0] lag,
  output var  logic       thread_switch_point,
  output var  logic [3:0] flag_clear
);
  // --------------------------------------------------------------------------
  // Scheduler
  // --------------------------------------------------------------------------
  logic [7:0] wait_reg;
  logic [1:0] state_reg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thread_switch_point <= 1'b0;
      flag_clear          <= 4'h0;
      wait_reg            <= 8'h0;
      state_reg           <= 2'd0;
    end else begin
      thread_switch_point <= 1'b0;
      flag_clear          <= 4'h0;
      case (state_reg)
        2'd0: if (service_request) begin
          wait_reg  <= lag;
          state_reg <= 2'd1;
        end
        2'd1: if (!service_request) begin
          state_reg <= 2'd0;
        end else if (wait_reg == 8'h0) begin
          thread_switch_point <= 1'b1;
          state_reg           <= 2'd2;
        end else begin
          wait_reg <= wait_reg - 8'h1;
        end
        2'd2: begin
          // Flags copied by the switch pulse settle one cycle later
          state_reg <= 2'd3;
        end
        default: begin
          flag_clear <= sampled_flags;
          state_reg  <= 2'd0;
        end
      endcase
    end
  end
endmodule // cmt_engine_model

`default_nettype wire

// *** test/cmt_channel_action_assertions.sv ***
/*
  Port assertions and covers for the channel action block.
  Assumes it is bound to cmt_channel_action and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module cmt_channel_action_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic [3:0]  addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        pin_out,
  input wire logic        thread_switch_point,
  input wire logic [3:0]  flag_clear,
  input wire logic        vector_first_match_second_edge,
  input wire logic        vector_second_match_first_edge,
  input wire logic        service_request,
  input wire logic [3:0]  sampled_flags,
  input wire logic [23:0] engine_capture_copy_a,
  input wire logic [23:0] engine_capture_copy_b
);
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cmt_cb @(posedge clk); endclocking
  default disable iff (!nrst);

  req_or_a: assert property (service_request ==
    (vector_first_match_second_edge | vector_second_match_first_edge))
    else $error("request is not the OR of the vectors");
  req_hold_a: assert property ($fell(service_request) |->
    ($past(flag_clear) != 4'h0) || $past(wr)) else $error("request dropped without a clear");
  flags_still_a: assert property (!($past(thread_switch_point) && $past(ce)) |->
    $stable(sampled_flags) && $stable(engine_capture_copy_a) && $stable(engine_capture_copy_b))
    else $error("engine copies changed without a thread switch");
  flags_seen_a: assert property (thread_switch_point && ce && service_request |=>
    sampled_flags != 4'h0) else $error("thread switch sampled no flag");
  read_idle_a: assert property ($past(ce) && !($past(rd) && ($past(addr) <= 4'h5)) |->
    rdata == 32'h0) else $error("read data outside its cycle");
  status_req_a: assert property (ce && rd && addr == 4'h3 |=>
    rdata[31:8] == 24'h0 && (|rdata[7:4]) == $past(service_request))
    else $error("status read disagrees with request");
  freeze_a: assert property (!ce |=> $stable(service_request) &&
    $stable(sampled_flags) && $stable(pin_out)) else $error("state moved with ce low");
  req_ce_a: assert property ($rose(service_request) |-> $past(ce))
    else $error("request rose while frozen");

  cover property ($rose(service_request));
  cover property ($rose(pin_out) ##1 $fell(pin_out));
  cover property (thread_switch_point && ce && service_request);
endmodule // cmt_channel_action_checker

bind cmt_channel_action cmt_channel_action_checker u_chk (.clk, .nrst, .ce, .addr, .wr,
  .rd, .rdata, .pin_out, .thread_switch_point, .flag_clear, .vector_first_match_second_edge,
  .vector_second_match_first_edge, .service_request, .sampled_flags,
  .engine_capture_copy_a, .engine_capture_copy_b);

`default_nettype wire

// *** test/cmt_channel_action_tb.sv ***
/*
  Testbench of the channel action block: registers, a table of mode cases
  served by the engine model, then random traffic.
  Assumes the design, its constants header, checker and engine model.
*/
`include "cmt_consts.vh"
`timescale 1ns/1ps
`default_nettype none

`define CMT_CHK(got, exp) begin checked++; if ((got) !== (exp)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp); end end

module cmt_channel_action_tb;
  localparam logic [23:0] far_off = 24'h400000;
  logic        clk, nrst, ce, wr, rd, pin_in, pin_out, thread_switch_point;
  logic        vec1, vec2, service_request;
  logic [3:0]  addr, flag_clear, sampled_flags, ra;
  logic [31:0] wdata, rdata, pexp, rw;
  logic [23:0] tb1, tb2, cap_a, cap_b, sh_a, sh_b;
  logic [11:0] r, sh_ctrl;
  bit          cv, pend;
  logic [7:0]  lag;
  int          error_cnt, checked, i, op;

  cmt_channel_action uut (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .timebase_counter_1(tb1), .timebase_counter_2(tb2),
    .thread_switch_point(thread_switch_point), .flag_clear(flag_clear),
    .vector_first_match_second_edge(vec1), .vector_second_match_first_edge(vec2),
    .service_request(service_request), .sampled_flags(sampled_flags),
    .engine_capture_copy_a(cap_a), .engine_capture_copy_b(cap_b));
  cmt_engine_model eng (.clk(clk), .nrst(nrst), .service_request(service_request),
    .sampled_flags(sampled_flags), .lag(lag), .thread_switch_point(thread_switch_point),
    .flag_clear(flag_clear));

  // --------------------------------------------------------------------------
  // Clock, timebases and tasks
  // --------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    tb1 <= tb1 + 24'h1;
    tb2 <= 24'($urandom);
  end

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic bus(input logic w, rr, input logic [3:0] a, input logic [31:0] d);
    wr <= w;
    rd <= rr;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, 1'b1, a, 32'h0);
    bus(1'b0, 1'b0, 4'h0, 32'h0);
    `CMT_CHK(rdata, e)
  endtask

  // Expected read data of the writable registers from the shadow copies
  function automatic logic [31:0] exp_rd(input logic [3:0] a);
    case (a)
      `CMT_ADDR_CTRL:    return {20'h0, sh_ctrl};
      `CMT_ADDR_MATCH_A: return {8'h0, sh_a};
      `CMT_ADDR_MATCH_B: return {8'h0, sh_b};
      default:           return 32'h0;
    endcase
  endfunction

  task automatic run_case(input logic [11:0] c, input logic [23:0] ma, mb,
    input logic [31:0] pat, input logic [7:0] lg, input logic [3:0] fl, input logic [1:0] vc);
    logic [23:0] t;
    logic [1:0]  v;
    int          hi, n;
    t = tb1;
    hi = 0;
    lag <= lg + 8'($urandom_range(0, 3));
    bus(1'b1, 1'b0, `CMT_ADDR_MATCH_A, {8'h0, t + ma});
    bus(1'b1, 1'b0, `CMT_ADDR_MATCH_B, {8'h0, t + mb});
    bus(1'b1, 1'b0, `CMT_ADDR_CTRL, {20'h0, c});
    wr <= 1'b0;
    for (n = 0; n < 300; n++) begin
      pin_in <= (n < 32) ? pat[n] : 1'b0;
      @(posedge clk);
      hi += int'(pin_out === 1'b1);
      if (thread_switch_point === 1'b1) break;
    end
    if (n == 300) begin
      error_cnt++;
      give_verdict();
    end
    v = {vec1, vec2};
    pin_in <= 1'b0;
    @(posedge clk);
    `CMT_CHK(sampled_flags, fl)
    `CMT_CHK(v, vc)
    if (c[2:0] == `CMT_MODE_ORD_ST) `CMT_CHK(hi, 1)
    if ((c[2:0] == 3'h1 || c[2:0] == 3'h2) && pat == 0) `CMT_CHK(cap_a, cap_b)
    if ((c[2:0] == 3'h1 || c[2:0] == 3'h2) && pat == 0) `CMT_CHK(cap_b, t + ma)
    bus(1'b1, 1'b0, `CMT_ADDR_CTRL, 32'h7);
    bus(1'b1, 1'b0, `CMT_ADDR_STATUS, 32'hf);
    bus(1'b0, 1'b0, 4'h0, 32'h0);
    repeat (12) @(posedge clk);
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(32'h79b92cd3));
    nrst = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    pin_in = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    lag = 8'h4;
    tb2 = 24'h0;
    tb1 = 24'($urandom_range(0, 32'hfffff));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(`CMT_ADDR_CTRL, {20'h0, `CMT_CTRL_RST});
    rd_chk(4'h9, 32'h0);
    bus(1'b1, 1'b0, `CMT_ADDR_CAPT_A, 32'hffffff);
    rd_chk(`CMT_ADDR_CAPT_A, 32'h0);
    r = 12'($urandom);
    bus(1'b1, 1'b0, `CMT_ADDR_CTRL, {20'h0, r});
    rd_chk(`CMT_ADDR_CTRL, {20'h0, r});
    rd_chk(`CMT_ADDR_STATUS, 32'h0);
    bus(1'b1, 1'b0, `CMT_ADDR_CTRL, 32'h7);
    run_case(12'h090, far_off, far_off, 32'h6, 8'd4, 4'hc, 2'b10);
    run_case(12'h050, far_off, far_off, 32'h5, 8'd4, 4'hc, 2'b10);
    run_case(12'h001, 24'd12, 24'd14, 32'h0, 8'd6, 4'h1, 2'b10);
    run_case(12'h001, 24'd12, 24'd12, 32'h0, 8'd6, 4'h3, 2'b11);
    run_case(12'hc05, 24'd12, 24'd12, 32'h0, 8'd6, 4'h3, 2'b01);
    run_case(12'h091, 24'd40, 24'd42, 32'h6, 8'd60, 4'hc, 2'b01);
    run_case(12'h013, far_off, 24'd30, 32'h6, 8'd20, 4'h2, 2'b01);
    run_case(12'h093, 24'd8, 24'd60, 32'h18000, 8'd60, 4'hd, 2'b01);
    run_case(12'h094, 24'd20, 24'd10, 32'h6000000, 8'd40, 4'h2, 2'b01);
    run_case(12'h094, 24'd8, 24'd60, 32'h18000, 8'd10, 4'hd, 2'b10);
    run_case(12'h096, 24'd8, 24'd16, 32'h300000, 8'd30, 4'h3, 2'b01);
    run_case(12'h096, 24'd8, 24'd60, 32'h18000, 8'd10, 4'hd, 2'b10);
    run_case(12'h092, 24'd12, 24'd14, 32'h0, 8'd6, 4'h1, 2'b10);
    run_case(12'h092, 24'd40, 24'd20, 32'h3ffffffc, 8'd40, 4'he, 2'b11);
    bus(1'b1, 1'b0, `CMT_ADDR_MATCH_A, 32'h0);
    bus(1'b1, 1'b0, `CMT_ADDR_MATCH_B, 32'h0);
    sh_ctrl = 12'h007;
    sh_a = 24'h0;
    sh_b = 24'h0;
    pend = 1'b0;
    pexp = 32'h0;
    for (i = 0; i < 400; i++) begin
      op = $urandom_range(0, 2);
      cv = ($urandom_range(0, 7) != 0);
      ra = 4'($urandom);
      rw = $urandom;
      ce <= cv;
      pin_in <= 1'($urandom);
      lag <= 8'($urandom_range(0, 5));
      bus(op == 1, op == 2, ra, rw);
      if (pend) `CMT_CHK(rdata, pexp)
      pend = cv && op == 2 && (ra <= 4'h2 || ra > 4'h5);
      pexp = exp_rd(ra);
      if (cv && op == 1 && ra == `CMT_ADDR_CTRL) sh_ctrl = rw[11:0];
      if (cv && op == 1 && ra == `CMT_ADDR_MATCH_A) sh_a = rw[23:0];
      if (cv && op == 1 && ra == `CMT_ADDR_MATCH_B) sh_b = rw[23:0];
    end
    ce <= 1'b1;
    bus(1'b0, 1'b0, 4'h0, 32'h0);
    if (pend) `CMT_CHK(rdata, pexp)
    give_verdict();
  end
endmodule // cmt_channel_action_tb

`default_nettype wire
